/* File: bench/chain_driver_model.sv */
`timescale 1ns/1ps
`default_nettype none
module chain_driver_model (
   // Chain pins.
   input  wire logic        chain_clk,
   input  wire logic        chain_sel,
   input  wire logic        chain_data,
   input  wire logic        select_polarity,
   output wire logic        chain_data_in,
   // Capture record.
   input  wire logic        clear,
   output var  logic [7:0]  bit_count,
   output var  logic [15:0] bits
);
   // Bits are taken on the rising chain clock while selected.
   always @(posedge chain_clk or posedge clear) begin
      if (clear) begin
         bit_count <= 8'h00;
         bits      <= 16'h0000;
      end else if (chain_sel == select_polarity) begin
         bit_count <= bit_count + 8'h01;
         bits      <= {bits[14:0], chain_data};
      end
   end
   // A deselected driver shows the inverse so a stale level cannot pass.
   assign chain_data_in = (chain_sel == select_polarity) ? bits[15] : ~bits[15];
endmodule
`default_nettype wire

/* File: bench/driver_chain_serial_config_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module driver_chain_serial_config_asserts (
   // Clock and reset.
   input wire logic       clk,
   input wire logic       reset,
   // Watched ports.
   input wire logic [6:0] chain_clock_divider,
   input wire logic       div_load,
   input wire logic       periodic_refresh,
   input wire logic       switch_mux_enable,
   input wire logic       select_polarity,
   input wire logic       signals_changed,
   input wire logic       chain_clk,
   input wire logic       chain_sel,
   input wire logic       chain_busy,
   input wire logic [5:0] ref_switch_state,
   input wire logic [6:0] div_setting
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic        prev_r;
   logic [7:0]  gap_r;
   logic        seen_r;
   logic        pend_r;
   logic [15:0] idle_r;
   wire         flip = chain_clk != prev_r;
   // Edge spacing is trusted only after a first edge inside the frame.
   always @(posedge clk) begin
      prev_r <= chain_clk;
      gap_r  <= flip ? 8'h00 : gap_r + 8'h01;
      seen_r <= chain_busy && !reset && (seen_r || flip);
      pend_r <= !reset && (signals_changed || (!$rose(chain_busy) && pend_r));
      idle_r <= (reset || chain_busy || !periodic_refresh) ? 16'h0000 : idle_r + 16'h0001;
   end
   sequence s_request;
      signals_changed && !chain_busy;
   endsequence
   a_div_default: assert property ($past(reset) |-> div_setting == 7'h0F)
      else $error("divider not at power-on value");
   a_div_loaded: assert property (div_load |=> div_setting == $past(chain_clock_divider))
      else $error("divider load lost");
   a_half_period: assert property (seen_r && chain_busy && flip && div_setting >= 7'h07
      |-> gap_r == {1'b0, div_setting})
      else $error("chain clock half period wrong");
   a_sel_active: assert property (chain_busy && $past(chain_busy) |-> chain_sel == select_polarity)
      else $error("select not active in frame");
   a_sel_idle: assert property (!chain_busy && !$past(chain_busy) && !$past(reset)
      && !switch_mux_enable && !$past(switch_mux_enable)
      |-> chain_sel == !select_polarity)
      else $error("select active while idle");
   a_request_busy: assert property (s_request |=> chain_busy)
      else $error("request not answered");
   a_no_demand: assert property ($rose(chain_busy) && !$past(periodic_refresh) |-> pend_r)
      else $error("frame without demand");
   a_refresh_due: assert property (periodic_refresh |-> idle_r < 16'h4E20)
      else $error("refresh frame missing");
   a_idle_sample: assert property (!chain_busy && !$past(chain_busy) |-> $stable(ref_switch_state))
      else $error("switches sampled while idle");
endmodule
bind driver_chain_serial_config driver_chain_serial_config_asserts chk (.clk(clk), .reset(reset),
   .chain_clock_divider(chain_clock_divider), .div_load(div_load),
   .periodic_refresh(periodic_refresh), .switch_mux_enable(switch_mux_enable),
   .select_polarity(select_polarity),
   .signals_changed(signals_changed), .chain_clk(chain_clk), .chain_sel(chain_sel),
   .chain_busy(chain_busy), .ref_switch_state(ref_switch_state), .div_setting(div_setting));
`default_nettype wire

/* File: bench/driver_chain_serial_config_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module driver_chain_serial_config_bench;
   logic clk, reset, host_valid, host_ready, host_rd_valid, div_load, periodic_refresh;
   logic switch_mux_enable, first_motor_right_switch, select_polarity, signals_changed;
   logic chain_clk, chain_sel, chain_data, chain_data_in, chain_busy, clear;
   logic ref_input_one, ref_input_two, ref_input_three;
   logic [31:0] host_word;
   logic [11:0] host_rd_data;
   logic [6:0]  chain_clock_divider, wave_a, wave_b, div_setting;
   logic [1:0]  last_driver_index;
   logic [29:0] motor_signals;
   logic [7:0]  wave_phase, bit_count;
   logic [5:0]  ref_switch_state;
   logic [15:0] bits;
   integer miscompares, checks_done, i, n;
   driver_chain_serial_config uut (.clk, .reset, .host_valid, .host_ready, .host_word,
      .host_rd_valid, .host_rd_data, .chain_clock_divider, .div_load, .periodic_refresh,
      .switch_mux_enable, .first_motor_right_switch, .last_driver_index, .select_polarity,
      .motor_signals, .signals_changed, .wave_phase, .wave_a, .wave_b, .chain_clk,
      .chain_sel, .chain_data, .chain_data_in, .ref_input_one, .ref_input_two,
      .ref_input_three, .ref_switch_state, .div_setting, .chain_busy);
   chain_driver_model drv (.chain_clk, .chain_sel, .chain_data, .select_polarity,
      .chain_data_in, .clear, .bit_count, .bits);
   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks; all of them start and end at a falling edge.
   task check(input logic [15:0] got, input logic [15:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task push(input logic [31:0] w);
      host_word = w;
      host_valid = 1'b1;
      for (n = 0; n < 5000 && host_ready !== 1'b1; n = n + 1) @(negedge clk);
      @(negedge clk);
      host_valid = 1'b0;
   endtask
   task read_loc(input logic half, input logic [4:0] loc, input logic [11:0] exp);
      push({1'b1, half, loc, 1'b1, 24'h000000});
      for (n = 0; n < 5000 && host_rd_valid !== 1'b1; n = n + 1) @(negedge clk);
      check({4'h0, host_rd_data}, {4'h0, exp});
   endtask
   task load_div(input logic [6:0] d);
      chain_clock_divider = d;
      div_load = 1'b1;
      @(negedge clk);
      div_load = 1'b0;
      @(negedge clk);
      check({9'h000, div_setting}, {9'h000, d});
   endtask
   task send;
      clear = 1'b1;
      signals_changed = 1'b1;
      @(negedge clk);
      clear = 1'b0;
      signals_changed = 1'b0;
      for (n = 0; n < 50 && chain_busy !== 1'b1; n = n + 1) @(negedge clk);
      for (n = 0; n < 20000 && chain_busy !== 1'b0; n = n + 1) @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task t_ram;
      push({8'hDA, 12'h000, 12'h5A3});
      read_loc(1'b1, 5'h05, 12'h000);
      push({8'hBA, 12'h000, 12'h9C6});
      read_loc(1'b0, 5'h1D, 12'h9C6);
      read_loc(1'b1, 5'h0D, 12'h5A3);
      push({8'h5B, 12'h000, 12'h000});
      for (i = 0; i < 40 && host_rd_valid !== 1'b1; i = i + 1) @(negedge clk);
      check({15'h0000, host_rd_valid}, 16'h0000);
   endtask
   task t_chain;
      push({8'h80, 12'h000, 12'hC31});
      push({8'h82, 12'h000, 12'hC32});
      load_div(7'h07);
      motor_signals = 30'h10000000;
      for (i = 0; i < 3; i = i + 1) begin
         last_driver_index = i[1:0];
         select_polarity = (i == 1);
         @(negedge clk);
         send;
         check({8'h00, bit_count}, i + 1);
         check(bits, (i == 0) ? 16'h0001 : (i == 1) ? 16'h0002 : 16'h0005);
      end
   endtask
   task t_switch;
      {ref_input_one, ref_input_two, ref_input_three} = 3'h7;
      send;
      check({10'h000, ref_switch_state}, 16'h0015);
      first_motor_right_switch = 1'b1;
      send;
      check({10'h000, ref_switch_state}, 16'h0007);
      {ref_input_one, ref_input_two, ref_input_three} = 3'h0;
      repeat (200) @(negedge clk);
      check({10'h000, ref_switch_state}, 16'h0007);
      switch_mux_enable = 1'b1;
      send;
      check({15'h0000, chain_busy}, 16'h0000);
   endtask
   task t_refresh;
      for (i = 0; i < 600 && chain_busy !== 1'b1; i = i + 1) @(negedge clk);
      check({15'h0000, chain_busy}, 16'h0000);
      periodic_refresh = 1'b1;
      for (i = 0; i < 5000 && chain_busy !== 1'b1; i = i + 1) @(negedge clk);
      check({15'h0000, chain_busy}, 16'h0001);
      periodic_refresh = 1'b0;
      for (i = 0; i < 20000 && chain_busy !== 1'b0; i = i + 1) @(negedge clk);
   endtask
   task t_fifo;
      integer acc;
      load_div(7'h7F);
      signals_changed = 1'b1;
      @(negedge clk);
      signals_changed = 1'b0;
      @(negedge clk);
      host_word = 32'h81000000;
      host_valid = 1'b1;
      acc = 0;
      for (i = 0; i < 8; i = i + 1) begin
         if (host_ready === 1'b1) acc = acc + 1;
         @(negedge clk);
      end
      host_valid = 1'b0;
      check(acc, 16'h0004);
      acc = 0;
      for (i = 0; i < 20000 && acc < 4; i = i + 1) begin
         if (host_rd_valid === 1'b1) acc = acc + 1;
         @(negedge clk);
      end
      check(acc, 16'h0004);
      check({4'h0, host_rd_data}, 16'h0C31);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, watchdog and main sequence.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #400000;
      miscompares = miscompares + 1;
      print_verdict;
   end
   initial begin
      {host_valid, div_load, periodic_refresh, switch_mux_enable, signals_changed} = 5'h00;
      {first_motor_right_switch, select_polarity, clear} = 3'h0;
      {ref_input_one, ref_input_two, ref_input_three} = 3'h0;
      {host_word, chain_clock_divider, last_driver_index} = 41'h0;
      {motor_signals, wave_phase} = 38'h0;
      miscompares = 0;
      checks_done = 0;
      reset = 1'b1;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      check({9'h000, div_setting}, 16'h000F);
      t_ram;
      t_chain;
      t_switch;
      t_refresh;
      t_fifo;
      print_verdict;
   end
endmodule
`default_nettype wire

/* File: rtl/chain_link_regs.vh */
`ifndef CHAIN_LINK_REGS_VH
`define CHAIN_LINK_REGS_VH
// Divider setting limits and power-on value.
`define DIV_W            7
`define DIV_MAX          7'h7F
`define DIV_MIN_SYM      7'h07
`define DIV_RESET        7'h0F
// RAM geometry: 64 locations of two 6-bit words, split by address bit 5.
`define RAM_LOCS         64
`define RAM_AW           6
`define CELL_W           6
`define CFG_NEXT_BIT     5
`define CODE_W           5
// Host word layout.
`define HOST_SEL_BIT     31
`define HOST_HALF_BIT    30
`define HOST_ADDR_LSB    25
`define HOST_WR_BIT      24
`define HOST_DATA_W      12
// Last driver index encodings.
`define LAST_ONE         2'h0
`define LAST_TWO         2'h1
`define LAST_THREE       2'h2
// Primary signal codes used by the selector.
`define CODE_PH_A        5'h06
`define CODE_FD_A        5'h07
`define CODE_PH_B        5'h0E
`define CODE_FD_B        5'h0F
`define CODE_ZERO        5'h10
`define CODE_ONE         5'h11
`define CODE_DIR         5'h12
`define CODE_STEP        5'h13
// Refresh interval in system clock cycles when idle with refresh on.
`define REFRESH_GAP      8'h40
// Host word FIFO shape.
`define FIFO_W           32
`define FIFO_D           4
`endif

/* File: rtl/driver_chain_serial_config.v */
`timescale 1ns/1ps
`default_nettype none
`include "chain_link_regs.vh"
// Overview of operation
// RULE1: chain clock frequency is system clock over two times divider plus one.
// RULE2: divider setting accepts up to 127, the slowest chain clock.
// RULE3: settings below 7 give no faster clock, only an asymmetric duty cycle.
// RULE4: divider setting is 15 after reset.
// RULE5: host should pick the fastest clock the slowest driver tolerates.
// RULE6: with refresh off, datagrams go out only when control signals change.
// RULE7: reference inputs are sampled only while a datagram is sent.
// RULE8: with refresh on, datagrams repeat even with all motors resting.
// RULE9: switch-halted motor restarts on next datagram seeing switch inactive.
// RULE10: host must enable refresh for auto stop, six switches, or idle reads.
// RULE11: in multiplex mode the select output also drives the switch mux.
// RULE12: multiplex enable overrides right-switch bit; multiplex defaults off.
// RULE13: default routing makes each input the left switch of one motor.
// RULE14: right-switch mode: input three is motor one right; motor three none.
// RULE15: RAM holds 64 locations of two six-bit words, twelve meaningful bits.
// RULE16: host word bit 31 picks registers or RAM.
// RULE17: host word bit 30 splits RAM into configuration and step table halves.
// RULE18: configuration words hold next flag and code, read from location zero.
// RULE19: each code selects one control signal of the addressed motor.
// RULE20: next flag advances driver address; at last index transfer ends.
// RULE21: one shared step table expands to full wave and 90 degree companion.
// RULE22: last driver index 0, 1, 2 means one, two, three drivers.
// RULE23: select output low active at polarity 0, high active at 1.
// RULE24: chain clock toggles every divider plus one system clock cycles.
module driver_chain_serial_config (
   // Clock and reset.
   input  wire        clk,
   input  wire        reset,
   // Host datagram stream into the block.
   input  wire        host_valid,
   output wire        host_ready,
   input  wire [31:0] host_word,
   // Host answer for RAM reads.
   output reg         host_rd_valid,
   output reg  [11:0] host_rd_data,
   // Configuration bits.
   input  wire [6:0]  chain_clock_divider,
   input  wire        div_load,
   input  wire        periodic_refresh,
   input  wire        switch_mux_enable,
   input  wire        first_motor_right_switch,
   input  wire [1:0]  last_driver_index,
   input  wire        select_polarity,
   // Motor control state, eight primary bits per motor plus direction and step.
   input  wire [29:0] motor_signals,
   input  wire        signals_changed,
   // Step table lookup: phase 0..255 in, two wave values out.
   input  wire [7:0]  wave_phase,
   output reg  [6:0]  wave_a,
   output reg  [6:0]  wave_b,
   // Driver chain pins.
   output reg         chain_clk,
   output reg         chain_sel,
   output reg         chain_data,
   input  wire        chain_data_in,
   // Reference switch inputs and results, divider setting readback and busy flag.
   input  wire        ref_input_one,
   input  wire        ref_input_two,
   input  wire        ref_input_three,
   output reg  [5:0]  ref_switch_state,
   output reg  [6:0]  div_setting,
   output reg         chain_busy
);
   localparam ST_IDLE = 2'h0;
   localparam ST_SEND = 2'h1;
   localparam ST_GAP  = 2'h2;

   reg  [`CELL_W-1:0] ram_r [0:2*`RAM_LOCS-1];
   reg  [1:0]         state_r;
   reg  [6:0]         div_cnt_r;
   reg  [6:0]         cell_r;
   reg  [1:0]         drv_r;
   reg  [29:0]        snap_r;
   reg  [7:0]         gap_r;
   reg                pending_r;
   reg                mux_phase_r;
   reg                started_r;
   reg                end_r;
   wire               tick;
   wire               fall;
   wire               f_valid;
   wire [31:0]        f_word;
   wire               f_ready;
   wire [`CELL_W-1:0] cfg;
   wire [6:0]         ram_idx;
   integer            i;

   ////////////////////////////////////////////////////////////////////////
   // Picks one buffered primary signal of the addressed motor.
   function sel_bit;
      input [29:0] snap;
      input [1:0]  drv;
      input [4:0]  code;
      reg   [9:0]  m;
      begin
         m = snap[drv*10 +: 10];
         sel_bit = 1'b0;
         case (code)
            `CODE_PH_A: sel_bit = m[0];
            `CODE_FD_A: sel_bit = m[1];
            `CODE_PH_B: sel_bit = m[2];
            `CODE_FD_B: sel_bit = m[3];
            `CODE_ZERO: sel_bit = 1'b0;
            `CODE_ONE:  sel_bit = 1'b1;
            `CODE_DIR:  sel_bit = m[8];
            `CODE_STEP: sel_bit = m[9];
            default:    sel_bit = (code[3:0] < 4'h6 || code[3:0] > 4'h7) ? m[4 + code[1:0]]
                                  : 1'b0;
         endcase
      end
   endfunction

   // Step table fetch with quarter wave folding.
   function [6:0] quarter;
      input [7:0] ph;
      input [2*`RAM_LOCS*`CELL_W-1:0] flat;
      reg   [5:0] idx;
      reg   [5:0] v;
      begin
         idx = ph[6] ? ~ph[5:0] : ph[5:0];
         v = flat[(`RAM_LOCS + idx)*`CELL_W +: `CELL_W];
         quarter = ph[7] ? -{1'b0, v} : {1'b0, v};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Host words pass through a small FIFO; the RAM side drains one a cycle.
   word_fifo #(.WIDTH(`FIFO_W), .DEPTH(`FIFO_D), .AW(2)) u_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (host_valid),
      .in_ready  (host_ready),
      .in_data   (host_word),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_word)
   );

   // Hold host RAM traffic while the chain reads configuration to avoid tearing.
   assign f_ready = (state_r != ST_SEND);
   assign ram_idx = {f_word[`HOST_HALF_BIT], f_word[`HOST_ADDR_LSB+4:`HOST_ADDR_LSB], 1'b0};
   assign cfg     = ram_r[cell_r];

   // Host RAM access: bit 31 picks RAM, bit 30 the half, two cells per location.
   always @(posedge clk) begin
      if (reset) begin
         host_rd_valid <= 1'b0;
         host_rd_data  <= 12'h000;
      end else begin
         host_rd_valid <= 1'b0;
         if (f_valid && f_ready && f_word[`HOST_SEL_BIT]) begin // RULE16 RULE17
            if (!f_word[`HOST_WR_BIT]) begin
               ram_r[ram_idx]        <= f_word[5:0];  // RULE15
               ram_r[ram_idx + 7'h01] <= f_word[11:6];
            end else begin
               host_rd_valid <= 1'b1;
               host_rd_data  <= {ram_r[ram_idx + 7'h01], ram_r[ram_idx]};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One shared table serves every motor; second wave is a quarter ahead.
   always @(posedge clk) begin
      if (reset) begin
         wave_a <= 7'h00;
         wave_b <= 7'h00;
      end else begin
         wave_a <= quarter(wave_phase, {ram_r[127], ram_r[126], ram_r[125], ram_r[124],
                   ram_r[123], ram_r[122], ram_r[121], ram_r[120], ram_r[119], ram_r[118],
                   ram_r[117], ram_r[116], ram_r[115], ram_r[114], ram_r[113], ram_r[112],
                   ram_r[111], ram_r[110], ram_r[109], ram_r[108], ram_r[107], ram_r[106],
                   ram_r[105], ram_r[104], ram_r[103], ram_r[102], ram_r[101], ram_r[100],
                   ram_r[99], ram_r[98], ram_r[97], ram_r[96], ram_r[95], ram_r[94],
                   ram_r[93], ram_r[92], ram_r[91], ram_r[90], ram_r[89], ram_r[88],
                   ram_r[87], ram_r[86], ram_r[85], ram_r[84], ram_r[83], ram_r[82],
                   ram_r[81], ram_r[80], ram_r[79], ram_r[78], ram_r[77], ram_r[76],
                   ram_r[75], ram_r[74], ram_r[73], ram_r[72], ram_r[71], ram_r[70],
                   ram_r[69], ram_r[68], ram_r[67], ram_r[66], ram_r[65], ram_r[64],
                   384'h0}); // RULE21
         wave_b <= quarter(wave_phase + 8'h40, {ram_r[127], ram_r[126], ram_r[125],
                   ram_r[124], ram_r[123], ram_r[122], ram_r[121], ram_r[120], ram_r[119],
                   ram_r[118], ram_r[117], ram_r[116], ram_r[115], ram_r[114], ram_r[113],
                   ram_r[112], ram_r[111], ram_r[110], ram_r[109], ram_r[108], ram_r[107],
                   ram_r[106], ram_r[105], ram_r[104], ram_r[103], ram_r[102], ram_r[101],
                   ram_r[100], ram_r[99], ram_r[98], ram_r[97], ram_r[96], ram_r[95],
                   ram_r[94], ram_r[93], ram_r[92], ram_r[91], ram_r[90], ram_r[89],
                   ram_r[88], ram_r[87], ram_r[86], ram_r[85], ram_r[84], ram_r[83],
                   ram_r[82], ram_r[81], ram_r[80], ram_r[79], ram_r[78], ram_r[77],
                   ram_r[76], ram_r[75], ram_r[74], ram_r[73], ram_r[72], ram_r[71],
                   ram_r[70], ram_r[69], ram_r[68], ram_r[67], ram_r[66], ram_r[65],
                   ram_r[64], 384'h0}); // RULE21
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Divider setting register; the full 7-bit range up to 127 is accepted.
   always @(posedge clk) begin
      if (reset) begin
         div_setting <= `DIV_RESET; // RULE4
      end else if (div_load) begin
         div_setting <= chain_clock_divider; // RULE2
      end
   end

   // Half-period counter: a toggle every setting plus one cycles gives
   // clk / (2*(n+1)). Below 7 the serial pipeline cannot keep up, so the
   // high phase is stretched to hold the period at 16 cycles and the duty cycle goes lopsided.
   assign tick = (div_cnt_r == 7'h00);
   // The first tick of a frame acts as a fall without moving the pin, so the
   // first bit is already on the data line before the first rising edge.
   assign fall = tick && (chain_clk || !started_r);
   always @(posedge clk) begin
      if (reset) begin
         div_cnt_r <= `DIV_RESET;
         chain_clk <= 1'b0;
         started_r <= 1'b0;
      end else if (state_r != ST_SEND) begin
         div_cnt_r <= div_setting;
         chain_clk <= 1'b0;
         started_r <= 1'b0;
      end else if (tick) begin
         started_r <= 1'b1;
         if (started_r) begin
            chain_clk <= ~chain_clk; // RULE1 RULE24
         end
         if (started_r && !chain_clk && div_setting < `DIV_MIN_SYM) begin
            div_cnt_r <= `DIV_MIN_SYM - div_setting + `DIV_MIN_SYM; // RULE3
         end else begin
            div_cnt_r <= div_setting;
         end
      end else begin
         div_cnt_r <= div_cnt_r - 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Datagram sequencer: snapshot, walk configuration words, shift bits out.
   always @(posedge clk) begin
      if (reset) begin
         state_r     <= ST_IDLE;
         cell_r      <= 7'h00;
         drv_r       <= `LAST_ONE;
         snap_r      <= 30'h0;
         gap_r       <= 8'h00;
         pending_r   <= 1'b0;
         chain_data  <= 1'b0;
         chain_busy  <= 1'b0;
         mux_phase_r <= 1'b0;
         end_r       <= 1'b0;
      end else begin
         // A change arriving during a send is remembered, never lost.
         if (signals_changed) begin
            pending_r <= 1'b1; // RULE6
         end
         case (state_r)
            ST_IDLE: begin
               if (pending_r || signals_changed || (periodic_refresh && gap_r == 8'h00)) begin
                  state_r    <= ST_SEND; // RULE8
                  snap_r     <= motor_signals;
                  pending_r  <= 1'b0;
                  cell_r     <= 7'h00; // RULE18
                  drv_r      <= `LAST_ONE;
                  chain_busy <= 1'b1;
               end else if (gap_r != 8'h00) begin
                  gap_r <= gap_r - 8'h01;
               end
            end
            ST_SEND: begin
               // The frame ends only after the rising edge that clocks the last bit.
               if (tick && end_r) begin
                  end_r   <= 1'b0;
                  state_r <= ST_GAP;
               end else if (fall && !end_r) begin
                  chain_data <= sel_bit(snap_r, drv_r, cfg[`CODE_W-1:0]); // RULE19
                  cell_r     <= cell_r + 7'h01;
                  if (cfg[`CFG_NEXT_BIT]) begin
                     if (drv_r == last_driver_index) begin // RULE20 RULE22
                        drv_r <= `LAST_ONE;
                        end_r <= 1'b1;
                     end else begin
                        drv_r <= drv_r + 2'h1;
                     end
                  end
                  if (cell_r == 7'h3F) begin
                     end_r <= 1'b1;
                  end
               end
            end
            ST_GAP: begin
               chain_busy  <= 1'b0;
               mux_phase_r <= ~mux_phase_r;
               gap_r       <= `REFRESH_GAP;
               state_r     <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Select pin; in multiplex mode it alternates per datagram to pick the group.
   always @(posedge clk) begin
      if (reset) begin
         chain_sel <= 1'b0;
      end else if (switch_mux_enable && state_r != ST_SEND) begin
         chain_sel <= mux_phase_r ^ ~select_polarity; // RULE11
      end else begin
         chain_sel <= (state_r == ST_SEND) ~^ select_polarity; // RULE23
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Switch sampling only during a send; layout {r3,l3,r2,l2,r1,l1}.
   always @(posedge clk) begin
      if (reset) begin
         ref_switch_state <= 6'h00;
      end else if (state_r == ST_SEND && fall) begin // RULE7 RULE9
         if (switch_mux_enable) begin // RULE12
            if (mux_phase_r) begin
               ref_switch_state[1] <= ref_input_one;
               ref_switch_state[3] <= ref_input_two;
               ref_switch_state[5] <= ref_input_three;
            end else begin
               ref_switch_state[0] <= ref_input_one;
               ref_switch_state[2] <= ref_input_two;
               ref_switch_state[4] <= ref_input_three;
            end
         end else if (first_motor_right_switch) begin
            ref_switch_state <= {2'b00, 1'b0, ref_input_two, ref_input_three,
                                 ref_input_one}; // RULE14
         end else begin
            ref_switch_state <= {1'b0, ref_input_three, 1'b0, ref_input_two, 1'b0,
                                 ref_input_one}; // RULE13
         end
      end
   end
endmodule
`default_nettype wire

/* File: rtl/word_fifo.v */
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   // Clock and reset.
   input  wire             clk,
   input  wire             reset,
   // Fill side.
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side.
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   localparam [AW:0] FULL_CNT = DEPTH;
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wr_r;
   reg [AW-1:0]    rd_r;
   reg [AW:0]      cnt_r;
   wire            push;
   wire            pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready  = (cnt_r != FULL_CNT);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data  = mem_r[rd_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointers wrap naturally because the depth is a power of two.
   always @(posedge clk) begin
      if (reset) begin
         wr_r  <= {AW{1'b0}};
         rd_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            mem_r[wr_r] <= in_data;
            wr_r        <= wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= rd_r + 1'b1;
         end
         cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule
`default_nettype wire
